/* File: hdl/qsfm_fifo.sv */
/*
  Read-data FIFO with valid/ready on both sides and a registered output stage.
  Assumes both sides run on clk; rst is synchronous and active high.
*/
`timescale 1ns/1ps
module qsfm_fifo #(
  parameter int WIDTH = qsfm_pkg::WORD_W,
  parameter int DEPTH = qsfm_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import qsfm_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic do_wr, do_rd;

  // Full is honest: in_ready drops once the memory holds DEPTH words
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  // Pointer, count and output stage next values
  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = (count_reg != '0) && (!out_valid_reg || out_ready);
    wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    out_valid_next = do_rd ? 1'b1 : (out_ready ? 1'b0 : out_valid_reg);
    out_data_next = do_rd ? mem[rd_ptr_reg] : out_data_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

  // Storage has no reset; only words behind a valid count are ever read
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule : qsfm_fifo

/* File: hdl/qsfm_master.sv */
/*
  Quad serial flash master: frames of programmable words read over 1, 2 or 4 lines,
  clock mode 0, words delivered through a FIFO. Configuration arrives on plain ports
  and is latched at start, except word_irq_en, read at each word, and frame_irq_en, read at the last word. Assumes flash data pins are asynchronous to clk.
*/
// Behaviour
// - Always master: generates sclk and chip select, never answers another master.
// - Reads words over one, two or four data lines, chosen per frame.
// - Word length programmable from 1 to 128 bits.
// - Word count programmable from 1 to 4096; exactly that many words per frame.
// - Three-pin, four-pin or six-pin interface selectable.
// - Optional completion pulse per word or per whole frame.
// - One to four sclk cycles between chip select and the first rising sclk edge.
// - Clock mode 0: sclk idles low, phase 0.
// - Read data sampled on the falling sclk edge.
// - Software gets whole words without handling single bits.
`timescale 1ns/1ps
module qsfm_master #(
  parameter int WORD_W = qsfm_pkg::WORD_W,
  parameter int LEN_W = qsfm_pkg::LEN_W,
  parameter int CNT_W = qsfm_pkg::CNT_W,
  parameter int DIV_W = qsfm_pkg::DIV_W,
  parameter int FIFO_DEPTH = qsfm_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] lane_mode,
  input wire logic [1:0] pin_mode,
  input wire logic [LEN_W-1:0] word_len_m1,
  input wire logic [CNT_W-1:0] word_cnt_m1,
  input wire logic [DIV_W-1:0] clk_div,
  input wire logic [1:0] cs_delay,
  input wire logic word_irq_en,
  input wire logic frame_irq_en,
  input wire logic [WORD_W-1:0] tx_word,
  output logic busy,
  output logic word_irq,
  output logic frame_irq,
  output logic [WORD_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] d_out,
  output logic [3:0] d_oe,
  input wire logic [3:0] d_in
);
  import qsfm_pkg::*;

  qsfm_state_type state_reg, state_next;
  logic [DIV_W:0] half_cnt_reg, half_cnt_next, half_load;
  logic sclk_reg, sclk_next, cs_n_reg, cs_n_next, drive_reg, drive_next;
  logic [2:0] dly_cnt_reg, dly_cnt_next;
  logic [7:0] clk_left_reg, clk_left_next;
  logic [CNT_W-1:0] word_idx_reg, word_idx_next;
  logic [WORD_W-1:0] rx_reg, rx_next, tx_reg, tx_next;
  logic [1:0] lane_reg, lane_next, pins_reg, pins_next;
  logic [LEN_W-1:0] len_reg, len_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic word_irq_reg, word_irq_next, frame_irq_reg, frame_irq_next;
  logic [3:0] d_meta_reg, d_sync_reg;
  logic tick, sample, push_valid, push_ready;
  logic [WORD_W-1:0] push_data;

  // Sclk cycles needed for one word: bits divided by lanes, rounded up
  function automatic logic [7:0] word_clocks(input logic [LEN_W-1:0] len, input logic [1:0] lane);
    logic [7:0] bits;
    bits = {1'b0, len} + 8'h01;
    if (lane == LANE_QUAD) begin
      word_clocks = (bits + 8'h03) >> 2;
    end else if (lane == LANE_DUAL) begin
      word_clocks = (bits + 8'h01) >> 1;
    end else begin
      word_clocks = bits;
    end
  endfunction : word_clocks

  // Keeps the low len+1 bits of a word
  function automatic logic [WORD_W-1:0] len_mask(input logic [LEN_W-1:0] len);
    len_mask = ~({WORD_W{1'b1}} << ({1'b0, len} + 8'h01));
  endfunction : len_mask

  // Left-justifies the outgoing word so its top bit leaves first
  function automatic logic [WORD_W-1:0] tx_align(input logic [WORD_W-1:0] w, input logic [LEN_W-1:0] len);
    tx_align = w << (LEN_W'(WORD_W - 1) - len);
  endfunction : tx_align

  // Two flops on the flash data pins; only the second flop is read by logic
  always_ff @(posedge clk) begin
    if (rst) begin
      d_meta_reg <= 4'h0;
      d_sync_reg <= 4'h0;
    end else begin
      d_meta_reg <= d_in;
      d_sync_reg <= d_meta_reg;
    end
  end

  // Half period is div+2 clocks, so the synchronised data is always settled
  assign half_load = {1'b0, div_reg} + (DIV_W+1)'(HALF_MIN_CYC - 1);
  assign tick = (half_cnt_reg == '0);
  assign sample = (state_reg == ST_SHIFT) && tick && sclk_reg;
  assign push_valid = (state_reg == ST_PUSH);
  assign push_data = rx_reg & len_mask(len_reg);

  // Frame sequencer next values
  always_comb begin
    state_next = state_reg;
    half_cnt_next = tick ? half_load : half_cnt_reg - 1'b1;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    drive_next = drive_reg;
    dly_cnt_next = dly_cnt_reg;
    clk_left_next = clk_left_reg;
    word_idx_next = word_idx_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    lane_next = lane_reg;
    pins_next = pins_reg;
    len_next = len_reg;
    cnt_next = cnt_reg;
    div_next = div_reg;
    word_irq_next = 1'b0;
    frame_irq_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        sclk_next = SCLK_RST;
        cs_n_next = CS_N_RST;
        drive_next = 1'b0;
        half_cnt_next = {1'b0, clk_div} + (DIV_W+1)'(HALF_MIN_CYC - 1);
        if (start) begin
          // Configuration other than word_irq_en and frame_irq_en is frozen for the frame so port changes cannot tear it
          lane_next = (pin_mode == PINS_6) ? lane_mode : LANE_SINGLE;
          pins_next = pin_mode;
          len_next = word_len_m1;
          cnt_next = word_cnt_m1;
          div_next = clk_div;
          dly_cnt_next = {cs_delay, 1'b0};
          word_idx_next = '0;
          cs_n_next = 1'b0;
          state_next = ST_CSDLY;
        end
      end
      ST_CSDLY: begin
        if (tick) begin
          if (dly_cnt_reg == 3'h0) begin
            // Data lines may only be driven once the delay has run out
            drive_next = (pins_reg == PINS_4);
            clk_left_next = word_clocks(len_reg, lane_reg);
            tx_next = tx_align(tx_word, len_reg);
            rx_next = '0;
            state_next = ST_SHIFT;
          end else begin
            dly_cnt_next = dly_cnt_reg - 3'h1;
          end
        end
      end
      ST_SHIFT: begin
        if (tick && !sclk_reg) begin
          sclk_next = 1'b1;
        end else if (sample) begin
          sclk_next = 1'b0;
          // The flash launched this bit on the previous falling edge
          if (lane_reg == LANE_QUAD) begin
            rx_next = {rx_reg[WORD_W-5:0], d_sync_reg};
          end else if (lane_reg == LANE_DUAL) begin
            rx_next = {rx_reg[WORD_W-3:0], d_sync_reg[1:0]};
          end else if (pins_reg == PINS_3) begin
            rx_next = {rx_reg[WORD_W-2:0], d_sync_reg[0]};
          end else begin
            rx_next = {rx_reg[WORD_W-2:0], d_sync_reg[1]};
          end
          tx_next = {tx_reg[WORD_W-2:0], 1'b0};
          clk_left_next = clk_left_reg - 8'h01;
          if (clk_left_reg == 8'h01) begin
            state_next = ST_PUSH;
          end
        end
      end
      ST_PUSH: begin
        // Sclk stays low here, so a full FIFO stalls the link instead of losing data
        half_cnt_next = half_load;
        if (push_ready) begin
          word_irq_next = word_irq_en;
          if (word_idx_reg == cnt_reg) begin
            frame_irq_next = frame_irq_en;
            state_next = ST_TAIL;
          end else begin
            word_idx_next = word_idx_reg + 1'b1;
            clk_left_next = word_clocks(len_reg, lane_reg);
            tx_next = tx_align(tx_word, len_reg);
            rx_next = '0;
            state_next = ST_SHIFT;
          end
        end
      end
      ST_TAIL: begin
        if (tick) begin
          cs_n_next = 1'b1;
          drive_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      half_cnt_reg <= '0;
      sclk_reg <= SCLK_RST;
      cs_n_reg <= CS_N_RST;
      drive_reg <= 1'b0;
      dly_cnt_reg <= 3'h0;
      clk_left_reg <= 8'h00;
      word_idx_reg <= '0;
      rx_reg <= '0;
      tx_reg <= '0;
      lane_reg <= LANE_SINGLE;
      pins_reg <= PINS_3;
      len_reg <= '0;
      cnt_reg <= '0;
      div_reg <= '0;
      word_irq_reg <= 1'b0;
      frame_irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      half_cnt_reg <= half_cnt_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      drive_reg <= drive_next;
      dly_cnt_reg <= dly_cnt_next;
      clk_left_reg <= clk_left_next;
      word_idx_reg <= word_idx_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      lane_reg <= lane_next;
      pins_reg <= pins_next;
      len_reg <= len_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      word_irq_reg <= word_irq_next;
      frame_irq_reg <= frame_irq_next;
    end
  end

  // Pin and status outputs, all straight from flops except busy, which is decoded from state_reg
  assign sclk = sclk_reg;
  assign cs_n = cs_n_reg;
  assign d_out = {3'h0, tx_reg[WORD_W-1]};
  assign d_oe = {3'h0, drive_reg};
  assign busy = (state_reg != ST_IDLE);
  assign word_irq = word_irq_reg;
  assign frame_irq = frame_irq_reg;

  // Whole words reach software through the FIFO
  qsfm_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // Checks on the frame sequencer
  a_sclk_idle_low: assert property (@(posedge clk) disable iff (rst) !busy |-> !sclk)
    else $error("sclk not low while idle");
  a_cs_whole_frame: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_SHIFT || state_reg == ST_PUSH) |-> !cs_n)
    else $error("chip select dropped inside frame");
  a_no_drive_idle: assert property (@(posedge clk) disable iff (rst) cs_n |-> (d_oe == 4'h0))
    else $error("data driven without chip select");
  a_sample_falls: assert property (@(posedge clk) disable iff (rst) sample |=> $fell(sclk))
    else $error("sample not on falling sclk edge");
  a_half_period: assert property (@(posedge clk) disable iff (rst) $rose(sclk) |=> sclk)
    else $error("sclk high phase shorter than two clocks");
  a_cs_lead: assert property (@(posedge clk) disable iff (rst) $fell(cs_n) |-> !sclk [*2])
    else $error("sclk rose too soon after chip select");
  a_word_total: assert property (@(posedge clk) disable iff (rst) frame_irq |-> $past(word_idx_reg) == cnt_reg)
    else $error("frame ended at wrong word count");
  a_irq_gated: assert property (@(posedge clk) disable iff (rst)
    word_irq |-> $past(push_valid && push_ready && word_irq_en))
    else $error("word pulse without completed word");
  a_word_masked: assert property (@(posedge clk) disable iff (rst)
    push_valid |-> (push_data & ~len_mask(len_reg)) == '0)
    else $error("word wider than programmed length");
  a_lane_input: assert property (@(posedge clk) disable iff (rst)
    (d_oe != 4'h0) |-> (d_oe == 4'h1 && pins_reg == PINS_4 && lane_reg == LANE_SINGLE))
    else $error("data line driven outside four-pin single mode");

  c_quad_frame: cover property (@(posedge clk) disable iff (rst) frame_irq && lane_reg == LANE_QUAD);
  c_fifo_stall: cover property (@(posedge clk) disable iff (rst) push_valid && !push_ready);
  c_long_delay: cover property (@(posedge clk) disable iff (rst) $fell(cs_n) && cs_delay == DLY_MAX);
endmodule : qsfm_master

/* File: hdl/qsfm_pkg.sv */
/*
  Constants and types shared by the quad serial flash master and its read FIFO.
  Assumes a single 100 MHz system clock; all serial timing is derived from it.
*/
package qsfm_pkg;
  // System clock
  localparam int unsigned CLK_HZ = 100_000_000;
  // Structural sizes (module parameters take these as defaults)
  localparam int WORD_W = 128;
  localparam int LEN_W = 7;
  localparam int CNT_W = 12;
  localparam int DIV_W = 8;
  localparam int FIFO_DEPTH = 16;
  // Data line modes
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;
  localparam logic [1:0] LANE_QUAD = 2'h2;
  // Pin configurations
  localparam logic [1:0] PINS_3 = 2'h0;
  localparam logic [1:0] PINS_4 = 2'h1;
  localparam logic [1:0] PINS_6 = 2'h2;
  // Values after reset, and the largest chip select delay
  localparam logic SCLK_RST = 1'b0;
  localparam logic CS_N_RST = 1'b1;
  localparam logic [1:0] DLY_MAX = 2'h3;
  // Least sclk half period in system clocks, needed by the two-flop input path
  localparam int HALF_MIN_CYC = 2;
  // Controller states
  typedef enum logic [2:0] {ST_IDLE, ST_CSDLY, ST_SHIFT, ST_PUSH, ST_TAIL} qsfm_state_type;
endpackage : qsfm_pkg

/* File: sim/qsfm_flash_model.sv */
/*
  Behavioural serial flash facing the quad master in its bench.
  Assumes clock mode 0 and a lane count handed in by the bench.
*/
`timescale 1ns/1ps
module qsfm_flash_model #(
  parameter logic [63:0] PAT = 64'hA5C3_0F96_3C5A_E187
) (
  input wire logic clk,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [2:0] lanes,
  input wire logic mosi,
  output logic [3:0] d_drv,
  output logic [127:0] rx_bits
);
  int idx = 0;
  // Next bits onto the lanes, earliest bit on the highest lane
  task automatic drive();
    logic b;
    for (int j = 0; j < lanes; j++) begin
      b = PAT[63 - ((idx + j) % 64)];
      if (lanes == 3'h1) d_drv[1:0] = {b, b};
      else d_drv[lanes - 1 - j] = b;
    end
  endtask : drive
  initial begin
    d_drv = 4'h0;
    rx_bits = '0;
  end
  // First bit on select, then one launch per falling clock
  always @(negedge cs_n) begin
    idx = 0;
    drive();
  end
  always @(negedge sclk) begin
    if (!cs_n) begin
      idx += lanes;
      drive();
    end
  end
  // Outgoing bit of the master taken on the rising clock
  always @(posedge sclk) begin
    if (!cs_n) rx_bits <= {rx_bits[126:0], mosi};
  end
  // No pull on the lines, so toggle while deselected; on the falling edge to stay clear of cs_n
  always @(negedge clk) begin
    if (cs_n) d_drv <= ~d_drv;
  end
endmodule : qsfm_flash_model

/* File: sim/quad_serial_flash_master_tb_top.sv */
/*
  Self-checking bench for the quad serial flash master: frames over every pin and lane mode.
  Assumes the flash model in qsfm_flash_model and the design's default parameters.
*/
`timescale 1ns/1ps
module quad_serial_flash_master_tb_top;
  import qsfm_pkg::*;
  localparam logic [63:0] PAT = 64'hA5C3_0F96_3C5A_E187;
  logic clk, rst, start, word_irq_en, frame_irq_en, rd_ready, cs_q;
  logic [1:0] lane_mode, pin_mode, cs_delay;
  logic [6:0] word_len_m1;
  logic [11:0] word_cnt_m1;
  logic [7:0] clk_div;
  logic [127:0] tx_word, rd_data, rx_bits;
  logic busy, word_irq, frame_irq, rd_valid, sclk, cs_n;
  logic [3:0] d_out, d_oe, d_in, flash_d;
  logic [2:0] lanes;
  int n_fail = 0;
  int checks = 0;
  int n_wirq, n_firq, n_csr, sidx;
  int wire_bad = 0;
  int cyc = 0;

  qsfm_master dut (.clk(clk), .rst(rst), .start(start), .lane_mode(lane_mode), .pin_mode(pin_mode),
    .word_len_m1(word_len_m1), .word_cnt_m1(word_cnt_m1), .clk_div(clk_div), .cs_delay(cs_delay),
    .word_irq_en(word_irq_en), .frame_irq_en(frame_irq_en), .tx_word(tx_word), .busy(busy),
    .word_irq(word_irq), .frame_irq(frame_irq), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .sclk(sclk), .cs_n(cs_n), .d_out(d_out), .d_oe(d_oe), .d_in(d_in));
  qsfm_flash_model #(.PAT(PAT)) flash (.clk(clk), .sclk(sclk), .cs_n(cs_n), .lanes(lanes),
    .mosi(d_out[0]), .d_drv(flash_d), .rx_bits(rx_bits));
  // Pin level from whichever side drives it
  assign d_in = (d_oe & d_out) | (~d_oe & flash_d);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task end_of_test();
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Word the flash stream yields: whole clocks of bits, latest len bits kept
  function automatic logic [127:0] exp_word(int base, int len, int n);
    logic [127:0] v;
    v = '0;
    for (int i = 0; i < ((len + n - 1) / n) * n; i++) v = {v[126:0], PAT[63 - ((base + i) % 64)]};
    return v & ((128'h1 << len) - 128'h1);
  endfunction : exp_word

  // Pulse counts, select releases, clock with no select, stray enables, run limit
  always @(posedge clk) begin
    if (!rst) begin
      if (word_irq === 1'b1) n_wirq++;
      if (frame_irq === 1'b1) n_firq++;
      if (cs_q === 1'b0 && cs_n === 1'b1) n_csr++;
      if ((cs_n === 1'b1 && sclk !== 1'b0) || d_oe[3:1] !== 3'h0) wire_bad++;
      if (pin_mode !== PINS_4 && d_oe[0] !== 1'b0) wire_bad++;
    end
    cs_q = cs_n;
    cyc++;
    if (cyc >= 20000) begin
      n_fail++;
      $display("[FAIL] cycle_limit expected below %0d seen %0d", 20000, cyc);
      end_of_test();
    end
  end

  task get_word(input logic [127:0] exp);
    int k;
    k = 0;
    while (rd_valid !== 1'b1 && k < 2000) begin
      step(1);
      k++;
    end
    // A word that never shows fails the rd_valid check, and rd_data is still compared
    chk("rd_valid", 1, rd_valid);
    chk("rd_data", exp, rd_data);
    step(1);
  endtask : get_word

  task run_frame(input logic [1:0] pm, lm, input int len, cnt, div, dly, input logic wen, fen, stall);
    int n, c, t;
    n = (pm != PINS_6) ? 1 : (lm == LANE_QUAD) ? 4 : (lm == LANE_DUAL) ? 2 : 1;
    c = (len + n - 1) / n;
    lanes = 3'(n);
    pin_mode = pm;
    lane_mode = lm;
    word_len_m1 = 7'(len - 1);
    word_cnt_m1 = 12'(cnt - 1);
    clk_div = 8'(div);
    cs_delay = 2'(dly);
    word_irq_en = wen;
    frame_irq_en = fen;
    rd_ready = 1'b0;
    n_wirq = 0;
    n_firq = 0;
    n_csr = 0;
    sidx = 0;
    start = 1'b1;
    step(1);
    start = 1'b0;
    chk("busy", 1, busy);
    t = 0;
    while (sclk !== 1'b1 && t < 500) begin
      step(1);
      t++;
    end
    chk("cs_to_sclk", (div + 2) * (2 + 2 * dly), t);
    chk("d_oe", (pm == PINS_4) ? 128'h1 : 128'h0, d_oe);
    if (c > 1) begin
      t = 0;
      while (sclk !== 1'b0 && t < 500) begin
        step(1);
        t++;
      end
      while (sclk !== 1'b1 && t < 500) begin
        step(1);
        t++;
      end
      chk("sclk_period", 2 * (div + 2), t);
    end
    // FIFO left full: the clock must park low and select stay asserted
    if (stall) begin
      step(1500);
      chk("stall_busy", 1, busy);
      chk("stall_sclk", 0, sclk);
      chk("stall_cs", 0, cs_n);
    end
    rd_ready = 1'b1;
    for (int w = 0; w < cnt; w++) begin
      if (w == 0 && cnt > 1) start = 1'b1;
      get_word(exp_word(sidx, len, n));
      start = 1'b0;
      sidx += c * n;
    end
    t = 0;
    while (busy !== 1'b0 && t < 500) begin
      step(1);
      t++;
    end
    chk("busy_end", 0, busy);
    step(2);
    chk("extra_word", 0, rd_valid);
    chk("word_irqs", wen ? cnt : 0, n_wirq);
    chk("frame_irqs", fen ? 1 : 0, n_firq);
    chk("cs_rises", 1, n_csr);
    chk("idle_sclk", 0, sclk);
    chk("idle_cs", 1, cs_n);
    if (pm == PINS_4) chk("tx_bits", tx_word & ((128'h1 << len) - 128'h1), rx_bits & ((128'h1 << len) - 128'h1));
    chk("wire_faults", 0, wire_bad);
  endtask : run_frame

  // Main sequence: reset, then one frame per pin and lane mode, stall case last
  initial begin
    rst = 1'b1;
    start = 1'b0;
    lane_mode = LANE_SINGLE;
    pin_mode = PINS_6;
    word_len_m1 = 7'h00;
    word_cnt_m1 = 12'h000;
    clk_div = 8'h00;
    cs_delay = 2'h0;
    word_irq_en = 1'b0;
    frame_irq_en = 1'b0;
    rd_ready = 1'b0;
    lanes = 3'h1;
    tx_word = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("rst_sclk", 0, sclk);
    chk("rst_cs", 1, cs_n);
    chk("rst_busy_valid_oe", 0, {busy, rd_valid, d_oe});
    run_frame(PINS_6, LANE_QUAD, 128, 2, 0, 0, 1, 1, 0);
    run_frame(PINS_6, LANE_DUAL, 7, 3, 1, 1, 1, 0, 0);
    run_frame(PINS_6, LANE_SINGLE, 9, 1, 0, 2, 0, 1, 0);
    run_frame(PINS_3, LANE_QUAD, 1, 1, 0, 3, 0, 0, 0);
    run_frame(PINS_4, LANE_SINGLE, 16, 2, 2, 1, 1, 1, 0);
    run_frame(PINS_6, LANE_QUAD, 5, 20, 0, 0, 1, 1, 1);
    end_of_test();
  end
endmodule : quad_serial_flash_master_tb_top
